//--- rtl/rscd_decoder.sv
// Purpose: Decodes latched device straps, exposes them over APB
// Assumes: APB master as per protocol; straps steady around reset release
// Notes:   Zero wait states; unmapped reads return zero with pslverr
//
// Implementation choices: the address map and register access over APB.
module rscd_decoder (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Strap pins
  input  wire logic        endianSelect,
  input  wire logic        hostWidthStrap,
  input  wire logic        pciSelect,
  input  wire logic        eepromAutoinitStrap,
  input  wire logic [1:0]  bootSelect,
  input  wire logic [1:0]  memClockSourceSelect,
  // Nonmaskable interrupt
  input  wire logic        nmiPin,
  output logic             nmiPulse,
  // Decoded configuration
  output logic             littleEndian,
  output logic             hostPort32bit,
  output logic             hostPortEnable,
  output logic             generalPurposePinsEnable,
  output logic             pciEnable,
  output logic             eepromAutoinitEnable,
  output logic [1:0]       bootMode,
  output logic             bootValid,
  output logic [1:0]       memClockSource,
  output logic             memClockValid,
  output logic [15:0]      hostDataUpperOe
);

// Overview of operation
// RQ1 - Endian pin low selects big-endian, high selects little-endian (default).
// RQ2 - Host width strap latched at reset: low 16-bit, high 32-bit.
// RQ3 - In 16-bit mode the upper sixteen host data pins stay undriven.
// RQ4 - PCI select low enables host port and pins 15..9; high enables PCI.
// RQ5 - EEPROM strap high enables PCI autoload; low disables it.
// RQ6 - Board keeps EEPROM strap low while PCI select is low.
// RQ7 - Boot 00 none, 01 host port, 10 reserved, 11 8-bit ROM.
// RQ8 - Board resistors must present a non-reserved boot selection.
// RQ9 - Memory clock 00 input, 01 CPU/4, 10 CPU/6, 11 reserved.
// RQ10 - NMI fires on rising edge only and no mask can block it.
// RQ11 - Straps captured at reset release and held until next reset.

  rscd_cfg_if cfg ();

  rscd_strap_latch u_latch (
    .sys_clk              (sys_clk),
    .rst                  (rst),
    .endianSelect         (endianSelect),
    .hostWidthStrapPin    (hostWidthStrap),
    .pciSelect            (pciSelect),
    .eepromAutoinitStrap  (eepromAutoinitStrap),
    .bootSelect           (bootSelect),
    .memClockSourceSelect (memClockSourceSelect),
    .cfg                  (cfg)
  );

  // ==========================================================================
  // Decode functions
  function automatic logic boot_ok(input logic [1:0] sel);
    boot_ok = (sel != rscd_pkg::BOOT_RESERVED);
  endfunction : boot_ok

  function automatic logic mclk_ok(input logic [1:0] sel);
    mclk_ok = (sel != rscd_pkg::MCLK_RESERVED);
  endfunction : mclk_ok

  // ==========================================================================
  // Decoded configuration registers
  logic        little_q, little_d;
  logic        hp32_q, hp32_d;
  logic        hpEn_q, hpEn_d;
  logic        pciEn_q, pciEn_d;
  logic        autold_q, autold_d;
  logic [1:0]  boot_q, boot_d;
  logic        bootOk_q, bootOk_d;
  logic [1:0]  mclk_q, mclk_d;
  logic        mclkOk_q, mclkOk_d;
  logic        confErr_q, confErr_d;
  logic [15:0] upperOe_q, upperOe_d;

  always_comb begin
    little_d  = cfg.endianSel;                          // [RQ1]
    hp32_d    = cfg.hostWidthStrap;                     // [RQ2]
    // Upper data pins only driven in 32-bit mode; oe low means drive
    upperOe_d = cfg.hostWidthStrap ? 16'h0000 : 16'hFFFF; // [RQ3]
    hpEn_d    = ~cfg.pciSel;                            // [RQ4]
    pciEn_d   = cfg.pciSel;                             // [RQ4]
    // Autoload only meaningful with PCI on
    autold_d  = cfg.eepromAutoinit & cfg.pciSel;        // [RQ5] [RQ6]
    confErr_d = cfg.eepromAutoinit & ~cfg.pciSel;       // [RQ6]
    boot_d    = cfg.bootSel;                            // [RQ7]
    bootOk_d  = boot_ok(cfg.bootSel);                   // [RQ7] [RQ8]
    mclk_d    = cfg.memClockSel;                        // [RQ9]
    mclkOk_d  = mclk_ok(cfg.memClockSel);               // [RQ9]
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      little_q  <= rscd_pkg::ENDIAN_RST;
      hp32_q    <= rscd_pkg::HWIDTH_RST;
      upperOe_q <= 16'hFFFF;
      hpEn_q    <= 1'h0;
      pciEn_q   <= 1'h0;
      autold_q  <= 1'h0;
      confErr_q <= 1'h0;
      boot_q    <= rscd_pkg::BOOT_RST;
      bootOk_q  <= 1'h0;
      mclk_q    <= rscd_pkg::MCLK_RST;
      mclkOk_q  <= 1'h0;
    end else begin
      little_q  <= little_d;
      hp32_q    <= hp32_d;
      upperOe_q <= upperOe_d;
      hpEn_q    <= hpEn_d;
      pciEn_q   <= pciEn_d;
      autold_q  <= autold_d;
      confErr_q <= confErr_d;
      boot_q    <= boot_d;
      bootOk_q  <= bootOk_d;
      mclk_q    <= mclk_d;
      mclkOk_q  <= mclkOk_d;
    end
  end

  // ==========================================================================
  // Nonmaskable interrupt edge detect, no mask in path
  logic nmiPrev_q, nmiPrev_d;
  logic nmiPulse_q, nmiPulse_d;
  logic nmiSeen_q, nmiSeen_d;
  logic apbClrNmi;

  always_comb begin
    nmiPrev_d  = nmiPin;
    nmiPulse_d = nmiPin & ~nmiPrev_q;                   // [RQ10]
    // Sticky seen flag; a new edge wins over a clear
    nmiSeen_d  = nmiPulse_d | (nmiSeen_q & ~apbClrNmi);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nmiPrev_q  <= 1'h0;
      nmiPulse_q <= 1'h0;
      nmiSeen_q  <= 1'h0;
    end else begin
      nmiPrev_q  <= nmiPrev_d;
      nmiPulse_q <= nmiPulse_d;
      nmiSeen_q  <= nmiSeen_d;
    end
  end

  // ==========================================================================
  // APB slave, zero wait states
  logic [31:0] prdata_q, prdata_d;
  logic        pslverr_q, pslverr_d;
  logic        pready_q, pready_d;
  logic        setup;
  logic [31:0] rdWord;
  logic        hit;

  assign setup = psel & ~penable & ~pready_q;

  always_comb begin
    rdWord = rscd_pkg::WORD_ZERO;
    hit    = 1'b1;
    unique case (paddr)
      rscd_pkg::STRAP_STATUS_OFS: begin
        rdWord[rscd_pkg::ENDIAN_POS]          = cfg.endianSel;
        rdWord[rscd_pkg::HWIDTH_POS]          = cfg.hostWidthStrap;
        rdWord[rscd_pkg::PCISEL_POS]          = cfg.pciSel;
        rdWord[rscd_pkg::EEPROM_AUTOINIT_STRAP_POS]            = cfg.eepromAutoinit;
        rdWord[rscd_pkg::BOOT_POS+:2]         = cfg.bootSel;
        rdWord[rscd_pkg::MCLK_POS+:2]         = cfg.memClockSel;
      end
      rscd_pkg::DECODE_OFS: begin
        rdWord[rscd_pkg::LITTLE_POS]          = little_q;
        rdWord[rscd_pkg::HP32_POS]            = hp32_q;
        rdWord[rscd_pkg::HPEN_POS]            = hpEn_q;
        rdWord[rscd_pkg::PCIEN_POS]           = pciEn_q;
        rdWord[rscd_pkg::AUTOLD_POS]          = autold_q;
        rdWord[rscd_pkg::BOOTV_POS]           = bootOk_q;
        rdWord[rscd_pkg::MCLKV_POS]           = mclkOk_q;
        rdWord[rscd_pkg::CONFERR_POS]         = confErr_q;
      end
      rscd_pkg::NMI_STATUS_OFS: begin
        rdWord[0] = nmiSeen_q;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  assign apbClrNmi = setup & pwrite & (paddr == rscd_pkg::NMI_STATUS_OFS)
                     & pwdata[0];

  always_comb begin
    pready_d  = setup;
    prdata_d  = (setup & ~pwrite) ? rdWord : rscd_pkg::WORD_ZERO;
    pslverr_d = setup & ~hit;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready_q  <= 1'h0;
      prdata_q  <= rscd_pkg::WORD_ZERO;
      pslverr_q <= 1'h0;
    end else begin
      pready_q  <= pready_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata                   = prdata_q;
  assign pready                   = pready_q;
  assign pslverr                  = pslverr_q;
  assign nmiPulse                 = nmiPulse_q;
  assign littleEndian             = little_q;
  assign hostPort32bit            = hp32_q;
  assign hostPortEnable           = hpEn_q;
  assign generalPurposePinsEnable = hpEn_q;
  assign pciEnable                = pciEn_q;
  assign eepromAutoinitEnable     = autold_q;
  assign bootMode                 = boot_q;
  assign bootValid                = bootOk_q;
  assign memClockSource           = mclk_q;
  assign memClockValid            = mclkOk_q;
  assign hostDataUpperOe          = upperOe_q;

  // ==========================================================================
  // Assertions
  sequence s_rise;
    !nmiPin ##1 nmiPin;
  endsequence

  a_nmi_on_rise: assert property (@(posedge sys_clk) disable iff (rst)
    s_rise |=> nmiPulse) // [RQ10]
    else $error("Rising NMI gave no pulse");
  a_nmi_only_rise: assert property (@(posedge sys_clk) disable iff (rst)
    nmiPulse |-> $past(nmiPin) && !$past(nmiPin, 2)) // [RQ10]
    else $error("NMI pulse without rising edge");
  a_endian_map: assert property (@(posedge sys_clk) disable iff (rst)
    cfg.captured |=> littleEndian == $past(cfg.endianSel)) // [RQ1]
    else $error("Endian decode wrong");
  a_width_map: assert property (@(posedge sys_clk) disable iff (rst)
    cfg.captured |=> hostPort32bit == $past(cfg.hostWidthStrap)) // [RQ2]
    else $error("Host width decode wrong");
  a_upper_hiz: assert property (@(posedge sys_clk) disable iff (rst)
    !hostPort32bit |-> hostDataUpperOe == 16'hFFFF) // [RQ3]
    else $error("Upper data driven in 16-bit mode");
  a_port_select: assert property (@(posedge sys_clk) disable iff (rst)
    cfg.captured ##1 cfg.captured |-> pciEnable != hostPortEnable) // [RQ4]
    else $error("Host port and PCI both or neither enabled");
  a_autoinit_gate: assert property (@(posedge sys_clk) disable iff (rst)
    eepromAutoinitEnable |-> pciEnable) // [RQ5]
    else $error("Autoload enabled without PCI");
  a_boot_valid: assert property (@(posedge sys_clk) disable iff (rst)
    cfg.captured ##1 cfg.captured |->
      bootValid == (bootMode != rscd_pkg::BOOT_RESERVED)) // [RQ7]
    else $error("Boot validity wrong");
  a_mclk_valid: assert property (@(posedge sys_clk) disable iff (rst)
    cfg.captured ##1 cfg.captured |->
      memClockValid == (memClockSource != rscd_pkg::MCLK_RESERVED)) // [RQ9]
    else $error("Memory clock validity wrong");
  a_cfg_stable: assert property (@(posedge sys_clk) disable iff (rst)
    cfg.captured ##2 cfg.captured |-> $stable(bootMode)) // [RQ11]
    else $error("Boot mode changed after capture");

endmodule : rscd_decoder

//--- rtl/rscd_pkg.sv
// Purpose: Shared constants for the reset strap configuration decoder
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses
package rscd_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [11:0] STRAP_STATUS_OFS = 12'h000;
  localparam logic [11:0] DECODE_OFS       = 12'h004;
  localparam logic [11:0] NMI_STATUS_OFS   = 12'h008;

  // ==========================================================================
  // Field positions of strap status word
  localparam int ENDIAN_POS    = 0;
  localparam int HWIDTH_POS    = 1;
  localparam int PCISEL_POS    = 2;
  localparam int EEPROM_AUTOINIT_STRAP_POS      = 3;
  localparam int BOOT_POS      = 4;
  localparam int MCLK_POS      = 6;

  // Field positions of decode word
  localparam int LITTLE_POS    = 0;
  localparam int HP32_POS      = 1;
  localparam int HPEN_POS      = 2;
  localparam int PCIEN_POS     = 3;
  localparam int AUTOLD_POS    = 4;
  localparam int BOOTV_POS     = 5;
  localparam int MCLKV_POS     = 6;
  localparam int CONFERR_POS   = 7;

  // ==========================================================================
  // Encodings
  localparam logic [1:0] BOOT_NONE     = 2'h0;
  localparam logic [1:0] BOOT_HOST     = 2'h1;
  localparam logic [1:0] BOOT_RESERVED = 2'h2;
  localparam logic [1:0] BOOT_ROM8     = 2'h3;
  localparam logic [1:0] MCLK_INPUT    = 2'h0;
  localparam logic [1:0] MCLK_DIV4     = 2'h1;
  localparam logic [1:0] MCLK_DIV6     = 2'h2;
  localparam logic [1:0] MCLK_RESERVED = 2'h3;

  // ==========================================================================
  // Reset values (pull defaults)
  localparam logic       ENDIAN_RST = 1'h1;
  localparam logic       HWIDTH_RST = 1'h0;
  localparam logic       PCISEL_RST = 1'h0;
  localparam logic       EEPROM_AUTOINIT_STRAP_RST   = 1'h0;
  localparam logic [1:0] BOOT_RST   = 2'h2;
  localparam logic [1:0] MCLK_RST   = 2'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    RSCD_IN_RESET = 2'b00,
    RSCD_CAPTURE  = 2'b01,
    RSCD_HOLD     = 2'b11
  } rscd_phase_type;

endpackage : rscd_pkg

//--- rtl/rscd_cfg_if.sv
// Purpose: Carries latched strap values between decoder modules
// Assumes: Single clock domain
// Notes:   Driven by the latch, read by the top
interface rscd_cfg_if;
  logic       endianSel;
  logic       hostWidthStrap;
  logic       pciSel;
  logic       eepromAutoinit;
  logic [1:0] bootSel;
  logic [1:0] memClockSel;
  logic       captured;

  modport latch (output endianSel, hostWidthStrap, pciSel, eepromAutoinit,
                 bootSel, memClockSel, captured);
  modport user  (input endianSel, hostWidthStrap, pciSel, eepromAutoinit,
                 bootSel, memClockSel, captured);
endinterface : rscd_cfg_if

//--- rtl/rscd_strap_latch.sv
// Purpose: Captures strap pins on reset release and holds them
// Assumes: Strap pins synchronous to sys_clk
// Notes:   Capture happens on the second edge after rst falls
module rscd_strap_latch (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Strap pins
  input  wire logic       endianSelect,
  input  wire logic       hostWidthStrapPin,
  input  wire logic       pciSelect,
  input  wire logic       eepromAutoinitStrap,
  input  wire logic [1:0] bootSelect,
  input  wire logic [1:0] memClockSourceSelect,
  // Latched values
  rscd_cfg_if.latch       cfg
);

  rscd_pkg::rscd_phase_type phase_q, phase_d;
  logic [7:0] straps_q, straps_d;

  always_comb begin
    phase_d  = phase_q;
    straps_d = straps_q;
    unique case (phase_q)
      rscd_pkg::RSCD_IN_RESET: begin
        phase_d = rscd_pkg::RSCD_CAPTURE;
      end
      rscd_pkg::RSCD_CAPTURE: begin
        // Sample once after release, then freeze [RQ11]
        straps_d = {memClockSourceSelect, bootSelect, eepromAutoinitStrap,
                    pciSelect, hostWidthStrapPin, endianSelect};
        phase_d  = rscd_pkg::RSCD_HOLD;
      end
      rscd_pkg::RSCD_HOLD: begin
        phase_d = rscd_pkg::RSCD_HOLD;
      end
      default: begin
        phase_d = rscd_pkg::RSCD_IN_RESET;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase_q  <= rscd_pkg::RSCD_IN_RESET;
      straps_q <= {rscd_pkg::MCLK_RST, rscd_pkg::BOOT_RST,
                   rscd_pkg::EEPROM_AUTOINIT_STRAP_RST, rscd_pkg::PCISEL_RST,
                   rscd_pkg::HWIDTH_RST, rscd_pkg::ENDIAN_RST};
    end else begin
      phase_q  <= phase_d;
      straps_q <= straps_d;
    end
  end

  assign cfg.endianSel      = straps_q[0];
  assign cfg.hostWidthStrap = straps_q[1];
  assign cfg.pciSel         = straps_q[2];
  assign cfg.eepromAutoinit = straps_q[3];
  assign cfg.bootSel        = straps_q[5:4];
  assign cfg.memClockSel    = straps_q[7:6];
  assign cfg.captured       = (phase_q == rscd_pkg::RSCD_HOLD);

  // ==========================================================================
  // Assertions
  a_straps_frozen: assert property (@(posedge sys_clk) disable iff (rst)
    $past(phase_q) == rscd_pkg::RSCD_HOLD |-> $stable(straps_q)) // [RQ11]
    else $error("Straps changed after capture");

endmodule : rscd_strap_latch

//--- tb/rscd_board_model.sv
// Purpose: Board strap resistors seen by the decoder's strap pins
// Assumes: Straps settle while rst is high
// Notes:   Pins turn into other functions a few cycles after release
module rscd_board_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Board setup
  input  wire logic [7:0] strapCfg,
  input  wire logic       faultyBoard,
  // Strap pins
  output logic            endianSelect,
  output logic            hostWidthStrap,
  output logic            pciSelect,
  output logic            eepromAutoinitStrap,
  output logic [1:0]      bootSelect,
  output logic [1:0]      memClockSourceSelect
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] relCnt_q = 3'h0;
  logic [2:0] relCnt_d;
  logic       toggle_q = 1'h1;
  logic       toggle_d;
  logic [7:0] shown;
  logic [7:0] pins;

  // ==========================================================================
  // Resistor fit
  always_comb begin
    shown = strapCfg;
    if (!faultyBoard && !strapCfg[2]) begin
      shown[3] = 1'h0;
    end
    if (!faultyBoard && strapCfg[5:4] == rscd_pkg::BOOT_RESERVED) begin
      shown[5:4] = rscd_pkg::BOOT_ROM8;
    end
  end

  // ==========================================================================
  // Pin reuse after release: pattern changes every cycle
  always_comb begin
    relCnt_d = rst ? 3'h0 : ((relCnt_q == 3'h7) ? 3'h7 : relCnt_q + 3'h1);
    toggle_d = (relCnt_q < 3'h4) ? 1'h1 : ~toggle_q;
  end

  always_ff @(posedge sys_clk) begin
    relCnt_q <= relCnt_d;
    toggle_q <= toggle_d;
  end

  assign pins = (relCnt_q < 3'h4) ? shown : shown ^ {8{toggle_q}};
  assign endianSelect         = pins[0];
  assign hostWidthStrap       = pins[1];
  assign pciSelect            = pins[2];
  assign eepromAutoinitStrap  = pins[3];
  assign bootSelect           = pins[5:4];
  assign memClockSourceSelect = pins[7:6];
endmodule : rscd_board_model

//--- tb/tb_top.sv
// Purpose: Self-checking bench of the strap decoder
// Assumes: APB slave answers within a few cycles
// Notes:   Board model changes pins after capture
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk, rst, psel, penable, pwrite, nmiPin, faultyBoard;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err;
  logic        endianSelect, hostWidthStrap, pciSelect, eepromAutoinitStrap;
  logic [1:0]  bootSelect, memClockSourceSelect, bootMode, memClockSource;
  logic        nmiPulse, littleEndian, hostPort32bit, hostPortEnable;
  logic        generalPurposePinsEnable, pciEnable, eepromAutoinitEnable;
  logic        bootValid, memClockValid;
  logic [15:0] hostDataUpperOe;
  logic [7:0]  strapCfg, c, e;
  int          fails, n_compared, i;

  rscd_decoder dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .endianSelect, .hostWidthStrap,
    .pciSelect, .eepromAutoinitStrap, .bootSelect, .memClockSourceSelect,
    .nmiPin, .nmiPulse, .littleEndian, .hostPort32bit, .hostPortEnable,
    .generalPurposePinsEnable, .pciEnable, .eepromAutoinitEnable, .bootMode,
    .bootValid, .memClockSource, .memClockValid, .hostDataUpperOe);

  rscd_board_model board_i (.sys_clk, .rst, .strapCfg, .faultyBoard,
    .endianSelect, .hostWidthStrap, .pciSelect, .eepromAutoinitStrap,
    .bootSelect, .memClockSourceSelect);

  // ==========================================================================
  // Reference model
  function automatic logic [7:0] board(input logic [7:0] s, input logic bad);
    logic [7:0] v;
    v = s;
    if (!bad && !s[2]) v[3] = 1'h0;
    if (!bad && s[5:4] == 2'h2) v[5:4] = 2'h3;
    return v;
  endfunction : board

  function automatic logic [31:0] decw(input logic [7:0] v);
    logic [31:0] w;
    w = rscd_pkg::WORD_ZERO;
    w[rscd_pkg::LITTLE_POS]  = v[0];
    w[rscd_pkg::HP32_POS]    = v[1];
    w[rscd_pkg::HPEN_POS]    = ~v[2];
    w[rscd_pkg::PCIEN_POS]   = v[2];
    w[rscd_pkg::AUTOLD_POS]  = v[3] & v[2];
    w[rscd_pkg::BOOTV_POS]   = (v[5:4] != 2'h2);
    w[rscd_pkg::MCLKV_POS]   = (v[7:6] != 2'h3);
    w[rscd_pkg::CONFERR_POS] = v[3] & ~v[2];
    return w;
  endfunction : decw

  // ==========================================================================
  // Checking and closing
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  // ==========================================================================
  // APB master
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (pready !== 1'h1) begin
      fails++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task rdchk(input logic [11:0] a, input logic [31:0] exp, input logic xe);
    apb(1'h0, a, 32'h0000_0000);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, xe});
  endtask : rdchk

  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    rst = 1'h1; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
    paddr = 12'h000; pwdata = 32'h0000_0000; nmiPin = 1'h0;
    strapCfg = 8'h00; faultyBoard = 1'h0; fails = 0; n_compared = 0;
    void'($urandom(90626));
    repeat (6) @(posedge sys_clk);
    for (i = 0; i < 8; i++) begin
      c = 8'($urandom);
      c[5:4] = 2'(i);
      c[7:6] = ~2'(i);
      c[1] = 1'(i);
      c[0] = 1'(i >> 2) ^ 1'(i);
      if (i >= 4) c[3:2] = 2'(i + 2);
      @(posedge sys_clk);
      rst <= 1'h1;
      strapCfg <= c;
      faultyBoard <= (i >= 4);
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(32'({littleEndian, hostPort32bit, hostPortEnable, pciEnable,
           bootMode, bootValid, memClockSource, memClockValid, nmiPulse}),
          32'h0000_0440);
      chk(32'(hostDataUpperOe), 32'h0000_FFFF);
      @(posedge sys_clk);
      rst <= 1'h0;
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk);
      e = board(c, i >= 4);
      chk(32'(littleEndian), 32'(e[0]));
      chk(32'(hostPort32bit), 32'(e[1]));
      chk(32'(hostDataUpperOe), e[1] ? 32'h0000_0000 : 32'h0000_FFFF);
      chk(32'({hostPortEnable, generalPurposePinsEnable, pciEnable}),
          32'({~e[2], ~e[2], e[2]}));
      chk(32'(eepromAutoinitEnable), 32'(e[3] & e[2]));
      chk(32'({bootMode, bootValid}),
          32'({e[5:4], e[5:4] != 2'h2}));
      chk(32'({memClockSource, memClockValid}),
          32'({e[7:6], e[7:6] != 2'h3}));
      rdchk(rscd_pkg::STRAP_STATUS_OFS, {24'h0, e}, 1'h0);
      rdchk(rscd_pkg::DECODE_OFS, decw(e), 1'h0);
      apb(1'h1, rscd_pkg::DECODE_OFS, $urandom);
      rdchk(rscd_pkg::DECODE_OFS, decw(e), 1'h0);
      $display("test strap set %0d done", i);
    end
    rdchk(12'h00C, 32'h0000_0000, 1'h1);
    rdchk(rscd_pkg::NMI_STATUS_OFS, 32'h0000_0000, 1'h0);
    @(posedge sys_clk);
    nmiPin <= 1'h1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk(32'(nmiPulse), 32'h0000_0001);
    for (i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      if (i == 4) begin
        nmiPin <= 1'h0;
      end
      @(negedge sys_clk);
      chk(32'(nmiPulse), 32'h0000_0000);
    end
    rdchk(rscd_pkg::NMI_STATUS_OFS, 32'h0000_0001, 1'h0);
    apb(1'h1, rscd_pkg::NMI_STATUS_OFS, 32'h0000_0001);
    rdchk(rscd_pkg::NMI_STATUS_OFS, 32'h0000_0000, 1'h0);
    $display("test interrupt and unmapped done");
    test_done();
  end
endmodule : tb_top
